//--- design/prt_tracker.sv
// Per-core patch revision tracker with signature register and load trigger.
`timescale 1ns/1ps

module prt_tracker
    import prt_pkg::*;
(
    input  wire logic                   clock,          // Core clock, 125 MHz.
    input  wire logic                   reset_n,        // Hard reset, asynchronous, active low.
    input  wire logic                   soft_init,      // Soft init pulse from the core.
    input  wire prt_reg_req_t           reg_req [PRT_THREADS], // Register access per thread.
    input  wire logic [PRT_THREADS-1:0] identify_exec,  // Identify instruction retired, per thread.
    input  wire logic [31:0]            update_revision, // Header revision of the update being loaded.
    output logic [63:0]                 read_data_q,    // Register read data.
    output logic                        read_valid_q,   // Read data valid pulse.
    output logic                        patch_active_q, // A patch is active in this core.
    output logic [31:0]                 active_revision_q, // Revision of the active patch.
    output logic                        load_reject_q   // Misaligned trigger rejected pulse.
);

    // ==========================================================
    // Thread arbitration
    // Lowest-numbered thread wins; firmware is expected to serialize anyway.
    function automatic int unsigned prt_pick(input logic [PRT_THREADS-1:0] req);
        int unsigned idx;
        idx = 0;
        for (int i = PRT_THREADS - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = unsigned'(i);
            end
        end
        return idx;
    endfunction

    // Address decode shared by the write path, the read path and the checks.
    function automatic logic prt_is_signature(input logic [31:0] addr);
        return addr == PRT_SIGNATURE_ADDR;
    endfunction

    function automatic logic prt_is_trigger(input logic [31:0] addr);
        return addr == PRT_TRIGGER_ADDR;
    endfunction

    logic [PRT_THREADS-1:0] req_valid;
    genvar g;
    generate
        for (g = 0; g < PRT_THREADS; g++)
        begin : gen_req
            assign req_valid[g] = reg_req[g].valid;
        end
    endgenerate

    prt_reg_req_t sel_req;
    logic         any_req;
    always_comb
    begin
        any_req = |req_valid;
        sel_req = reg_req[prt_pick(req_valid)];
    end

    logic wr_sig;
    logic wr_trig;
    logic rd_any;
    logic trig_aligned;
    assign wr_sig       = any_req && sel_req.write && prt_is_signature(sel_req.addr);
    assign wr_trig      = any_req && sel_req.write && prt_is_trigger(sel_req.addr);
    assign rd_any       = any_req && !sel_req.write;
    assign trig_aligned = (sel_req.wdata[3:0] & PRT_ALIGN_MASK) == 4'h0;

    // ==========================================================
    // Load sequencer
    prt_state_t state_q;
    prt_load_t  load_q;
    // A trigger that arrives while a load is under way is dropped, not queued.
    // Firmware serializes its loads, so a queue would only cost area.

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= PRT_IDLE;
        end
        else
        begin
            unique case (state_q)
                PRT_IDLE:
                begin
                    if (wr_trig && trig_aligned)
                    begin
                        state_q <= PRT_LOAD;
                    end
                end
                PRT_LOAD:
                begin
                    state_q <= PRT_REPORT;
                end
                PRT_REPORT:
                begin
                    state_q <= PRT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            load_q <= '0;
        end
        // The header revision is captured in the trigger cycle.
        // That is the only cycle in which the image is known to stand behind the address.
        else if (state_q == PRT_IDLE && wr_trig && trig_aligned)
        begin
            load_q.valid    <= 1'b1;
            load_q.address  <= sel_req.wdata;
            load_q.revision <= update_revision;
        end
        else if (state_q == PRT_REPORT)
        begin
            load_q.valid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            load_reject_q <= 1'b0;
        end
        else
        begin
            load_reject_q <= wr_trig && !trig_aligned;
        end
    end

    // ==========================================================
    // Active patch state
    // private per-core state
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            patch_active_q    <= 1'b0;
            active_revision_q <= PRT_REV_NONE;
        end
        else if (state_q == PRT_LOAD)
        begin
            patch_active_q    <= 1'b1;
            active_revision_q <= load_q.revision;
        end
    end

    // ==========================================================
    // Signature register
    logic [63:0] signature_q;
    logic        identify_any;
    assign identify_any = |identify_exec;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            signature_q <= PRT_SIGNATURE_RST;
        end
        else if (identify_any && patch_active_q)
        begin
            signature_q[PRT_REV_LSB +: PRT_REV_W] <= active_revision_q;
        end
        else if (wr_sig)
        begin
            signature_q <= sel_req.wdata;
        end
    end

    // ==========================================================
    // Read path
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            read_data_q  <= 64'h0000_0000_0000_0000;
            read_valid_q <= 1'b0;
        end
        else
        begin
            read_valid_q <= rd_any;
            // read has no side effect
            // Unmapped addresses and the write-only trigger read as zero.
            read_data_q  <= (rd_any && prt_is_signature(sel_req.addr)) ? signature_q : 64'h0000_0000_0000_0000;
        end
    end

    // ==========================================================
    // Checks
    // unpatched means zero revision
    unpatched_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        !patch_active_q |-> active_revision_q == PRT_REV_NONE)
        else $error("Unpatched core carries a non-zero revision.");

    identify_deposit_a: assert property (@(posedge clock) disable iff (!reset_n)
        (identify_any && patch_active_q) |=> signature_q[63:32] == $past(active_revision_q))
        else $error("Identify did not deposit the active revision.");

    no_patch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        (identify_any && !patch_active_q && !wr_sig) |=> $stable(signature_q))
        else $error("Signature changed with no active patch.");

    load_revision_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == PRT_IDLE && wr_trig && trig_aligned) |-> ##2 active_revision_q == $past(update_revision, 2))
        else $error("Active revision differs from loaded header.");

    soft_init_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        (soft_init && patch_active_q && state_q != PRT_LOAD) |=> patch_active_q && $stable(active_revision_q))
        else $error("Soft init disturbed the active patch.");

    read_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rd_any && state_q == PRT_IDLE) |=> $stable(patch_active_q) && $stable(active_revision_q))
        else $error("Signature read disturbed the patch.");

    misalign_reject_a: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_trig && !trig_aligned && state_q == PRT_IDLE) |=> state_q == PRT_IDLE && load_reject_q)
        else $error("Misaligned trigger was not rejected.");

    reload_same_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == PRT_LOAD && patch_active_q && load_q.revision == active_revision_q)
        |=> patch_active_q && $stable(active_revision_q))
        else $error("Repeated load changed core state.");

    read_layout_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rd_any && sel_req.addr == PRT_SIGNATURE_ADDR) |=> read_valid_q && read_data_q == $past(signature_q))
        else $error("Signature read returned wrong data.");

    // ==========================================================
    // Sequencer, reset and register path checks

    load_pending_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == PRT_LOAD |-> load_q.valid)
        else $error("Load state entered without a pending load.");

    load_aligned_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == PRT_LOAD |-> load_q.address[3:0] == 4'h0)
        else $error("Misaligned image reached the loader.");

    // Reset release is checked without the disable so the cleared state is seen at the first edge.
    reset_clear_a: assert property (@(posedge clock)
        $rose(reset_n) |-> !patch_active_q && active_revision_q == PRT_REV_NONE
        && signature_q == PRT_SIGNATURE_RST)
        else $error("Hard reset left patch state behind.");

    patch_sticky_a: assert property (@(posedge clock) disable iff (!reset_n)
        patch_active_q |=> patch_active_q)
        else $error("Active patch dropped without a hard reset.");

    load_start_a: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == PRT_IDLE && wr_trig && trig_aligned) |=> state_q == PRT_LOAD)
        else $error("Aligned trigger did not start a load.");

    load_finish_a: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == PRT_LOAD |=> patch_active_q && active_revision_q == $past(load_q.revision))
        else $error("Load did not activate the captured revision.");

    state_onehot_a: assert property (@(posedge clock) disable iff (!reset_n)
        $onehot(state_q))
        else $error("Load sequencer left its one-hot codes.");

    read_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        rd_any |=> read_valid_q)
        else $error("Read request got no valid pulse.");

    idle_read_a: assert property (@(posedge clock) disable iff (!reset_n)
        !rd_any |=> !read_valid_q)
        else $error("Read valid pulsed without a request.");

    trigger_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
        (rd_any && prt_is_trigger(sel_req.addr)) |=> read_data_q == 64'h0000_0000_0000_0000)
        else $error("Trigger address read returned data.");

    sig_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        (wr_sig && !(identify_any && patch_active_q)) |=> signature_q == $past(sel_req.wdata))
        else $error("Signature write was not stored as written.");

    low_half_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        (identify_any && patch_active_q) |=> signature_q[31:0] == $past(signature_q[31:0]))
        else $error("Identify disturbed the reserved low half.");

    reject_cause_a: assert property (@(posedge clock) disable iff (!reset_n)
        load_reject_q |-> $past(wr_trig && !trig_aligned))
        else $error("Reject pulse without a misaligned trigger.");

endmodule

//--- design/prt_pkg.sv
// Package for the patch revision tracker: register addresses, field layout and types.
package prt_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [31:0] PRT_SIGNATURE_ADDR = 32'h0000_008B;
    localparam logic [31:0] PRT_TRIGGER_ADDR   = 32'h0000_0079;

    // ==========================================================
    // Field layout and reset values
    localparam int          PRT_REV_LSB        = 32;
    localparam int          PRT_REV_W          = 32;
    localparam logic [63:0] PRT_SIGNATURE_RST  = 64'h0000_0000_0000_0000;
    localparam logic [31:0] PRT_REV_NONE       = 32'h0000_0000;
    localparam logic [3:0]  PRT_ALIGN_MASK     = 4'hF;
    localparam int          PRT_THREADS        = 2;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [63:0] wdata;
    } prt_reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] address;
        logic [31:0] revision;
    } prt_load_t;

    typedef enum logic [2:0] {
        PRT_IDLE   = 3'b001,
        PRT_LOAD   = 3'b010,
        PRT_REPORT = 3'b100
    } prt_state_t;

endpackage

//--- verif/prt_image_model.sv
// Firmware-side model of the update images behind the load trigger.
`timescale 1ns/1ps
module prt_image_model
    import prt_pkg::*;
(
    input  wire logic         clock,                 // Core clock.
    input  wire prt_reg_req_t reg_req [PRT_THREADS], // Firmware register requests.
    output logic [31:0]       update_revision        // Header revision at trigger address.
);
    logic [31:0] last_q = 32'h0000_0000;
    logic [31:0] addr;
    logic        trig;
    // each distinct value of trigger address bits 31:4 maps to its own image.
    always_comb
    begin
        trig = 1'b0;
        addr = 32'h0000_0000;
        for (int i = PRT_THREADS - 1; i >= 0; i--)
        begin
            if (reg_req[i].valid && reg_req[i].write && reg_req[i].addr == PRT_TRIGGER_ADDR)
            begin
                trig = 1'b1;
                addr = reg_req[i].wdata[31:0];
            end
        end
    end
    // revisions are never zero, so any image is newer than an unpatched core.
    // Outside a trigger the value is inverted so a stale sample shows.
    assign update_revision = trig ? {addr[31:4] ^ 28'h5A5_A5A5, 4'h1} : ~last_q;
    always_ff @(posedge clock)
    begin
        last_q <= update_revision;
    end
endmodule

//--- verif/test_prt_tracker.sv
// Self-checking bench for the patch revision tracker.
`timescale 1ns/1ps
module test_prt_tracker
    import prt_pkg::*;
;
    logic                   clock;
    logic                   reset_n;
    logic                   soft_init;
    prt_reg_req_t           reg_req [PRT_THREADS];
    logic [PRT_THREADS-1:0] identify_exec;
    logic [31:0]            update_revision;
    logic [63:0]            read_data_q;
    logic                   read_valid_q;
    logic                   patch_active_q;
    logic [31:0]            active_revision_q;
    logic                   load_reject_q;
    logic [63:0]            exp_q [$];
    logic [31:0]            seed;
    logic [31:0]            addr;
    int                     n_mismatch;
    int                     comparisons;

    prt_tracker u_prt_tracker (.clock(clock), .reset_n(reset_n), .soft_init(soft_init), .reg_req(reg_req),
        .identify_exec(identify_exec), .update_revision(update_revision), .read_data_q(read_data_q),
        .read_valid_q(read_valid_q), .patch_active_q(patch_active_q),
        .active_revision_q(active_revision_q), .load_reject_q(load_reject_q));
    prt_image_model u_prt_image_model (.clock(clock), .reg_req(reg_req), .update_revision(update_revision));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] rev_of(input logic [31:0] a);
        return {a[31:4] ^ 28'h5A5_A5A5, 4'h1};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        comparisons++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic access(input int t, input logic w, input logic [31:0] a, input logic [63:0] d);
        @(posedge clock);
        #1;
        reg_req[t] = '{1'b1, w, a, d};
        @(posedge clock);
        #1;
        reg_req[t].valid = 1'b0;
    endtask
    task automatic rd(input int t, input logic [31:0] a, input logic [63:0] want);
        exp_q.push_back(want);
        access(t, 1'b0, a, 64'h0);
    endtask
    task automatic identify(input int t);
        @(posedge clock);
        #1;
        identify_exec[t] = 1'b1;
        @(posedge clock);
        #1;
        identify_exec[t] = 1'b0;
    endtask
    function automatic logic [31:0] image_sum(input logic [31:0] a);
        return rev_of(a) + (32'h0000_0000 - rev_of(a));
    endfunction
    task automatic load(input int t, input logic [31:0] a);
        if (image_sum(a) == 32'h0000_0000)
        begin
            access(t, 1'b1, PRT_TRIGGER_ADDR, {32'h0, a});
        end
        repeat (2) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // Clock, watchdog and read monitor
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        #40000;
        n_mismatch++;
        summarize();
    end
    // An unexpected read pulse compares against an inverted value so it always counts.
    always @(posedge clock)
    begin
        if (read_valid_q === 1'b1)
            check(read_data_q, exp_q.size() > 0 ? exp_q.pop_front() : ~read_data_q);
    end

    // ==========================================================
    // Scenarios
    initial
    begin
        reset_n = 1'b0;
        soft_init = 1'b0;
        identify_exec = '0;
        reg_req = '{default: '0};
        seed = 32'hFD19;
        repeat (20) @(posedge clock);
        #1 reset_n = 1'b1;
        rd(0, PRT_SIGNATURE_ADDR, PRT_SIGNATURE_RST);
        seed = lfsr(seed);
        access(1, 1'b1, PRT_SIGNATURE_ADDR, {32'h0, ~seed});
        identify(0);
        rd(1, PRT_SIGNATURE_ADDR, {32'h0, ~seed});
        check(patch_active_q, 64'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            addr = {{4'(i + 1), seed[27:4]} ^ 28'h5A5_A5A5, 4'h0};
            load(i % 2, addr);
            load(i % 2, addr);
            check({patch_active_q, active_revision_q}, {31'h0, 1'b1, rev_of(addr)});
            access(0, 1'b1, PRT_SIGNATURE_ADDR, {32'h0, seed});
            identify(1 - i % 2);
            rd(0, PRT_SIGNATURE_ADDR, {rev_of(addr), seed});
            rd(1, PRT_SIGNATURE_ADDR, {rev_of(addr), seed});
            check(active_revision_q, rev_of(addr));
        end
        @(posedge clock);
        #1 soft_init = 1'b1;
        @(posedge clock);
        #1 soft_init = 1'b0;
        check({patch_active_q, active_revision_q}, {31'h0, 1'b1, rev_of(addr)});
        access(1, 1'b1, PRT_TRIGGER_ADDR, {32'h0, addr | 32'h8});
        check(load_reject_q, 64'h1);
        repeat (2) @(posedge clock);
        check(active_revision_q, rev_of(addr));
        rd(0, PRT_TRIGGER_ADDR, 64'h0);
        @(posedge clock);
        #1 reset_n = 1'b0;
        @(posedge clock);
        #1 reset_n = 1'b1;
        check({patch_active_q, active_revision_q}, 64'h0);
        access(0, 1'b1, PRT_SIGNATURE_ADDR, 64'h0);
        identify(1);
        rd(0, PRT_SIGNATURE_ADDR, PRT_SIGNATURE_RST);
        load(1, addr);
        check({patch_active_q, active_revision_q}, {31'h0, 1'b1, rev_of(addr)});
        fork
            access(0, 1'b1, PRT_SIGNATURE_ADDR, {32'h0, seed});
            identify(0);
        join
        rd(1, PRT_SIGNATURE_ADDR, {rev_of(addr), 32'h0});
        repeat (3) @(posedge clock);
        check(64'(exp_q.size()), 64'h0);
        summarize();
    end
endmodule
